// *** rtl/swg_pkg.sv ***
// constants and types shared by the sleep wake source gating block
package swg_pkg;
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned NUM_PIN = 2;
  localparam int unsigned ADDR_W  = 5;

  // source positions, shared by enable, status, mask and event vectors
  localparam int unsigned SRC_PULSE  = 0;
  localparam int unsigned SRC_FMCH1  = 1;
  localparam int unsigned SRC_FMCH2  = 2;
  localparam int unsigned SRC_ORIENT = 3;
  localparam int unsigned SRC_JOLT   = 4;

  // register byte offsets
  localparam logic [4:0] OFS_WAKE_EN  = 5'h00;
  localparam logic [4:0] OFS_PIN_CFG  = 5'h04;
  localparam logic [4:0] OFS_EVT_STAT = 5'h08;
  localparam logic [4:0] OFS_EVT_MASK = 5'h0c;
  localparam logic [4:0] OFS_STATE    = 5'h10;

  // field positions
  localparam int unsigned POS_POLARITY = 0;
  localparam int unsigned POS_SLEEP    = 0;
  localparam int unsigned POS_WAKE_REQ = 1;
  localparam int unsigned POS_RAW_EVT  = 8;

  // reset values
  localparam logic [4:0] RST_WAKE_EN  = 5'h00;
  localparam logic       RST_POLARITY = 1'h0;
  localparam logic [4:0] RST_EVT_MASK = 5'h00;
  localparam logic [1:0] RST_PIN      = 2'h3;

  typedef logic [NUM_SRC-1:0] swg_src_t;
endpackage

// *** rtl/swg_gate_if.sv ***
// bundle between the register side and the wake gate
`timescale 1ns/1ps
interface swg_gate_if;
  logic [4:0] wake_en;
  logic [4:0] events;
  logic       sleep;
  logic [4:0] hit;
  modport gate (input wake_en, input events, input sleep, output hit);
  modport ctrl (output wake_en, output events, output sleep, input hit);
endinterface

// *** rtl/swg_wake_gate.sv ***
// per-source wake gating during sleep
`timescale 1ns/1ps
module swg_wake_gate (
  swg_gate_if.gate gif
);
  import swg_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_SRC; i++) begin : g_src
      // disabled sources are simply bypassed while asleep
      assign gif.hit[i] = gif.sleep & gif.wake_en[i] & gif.events[i]; // R01 R02 R03 R04 R07
    end
  endgenerate
endmodule

// *** rtl/swg_top.sv ***
// sleep wake source gating with avalon register slave and pin polarity
// Overview of operation
// R01 - pulse wakes only when its enable set
// R02 - motion channel 1 wakes only when enabled
// R03 - motion channel 2 wakes only when enabled
// R04 - orientation wakes when its enable set
// R05 - pin polarity setting, resets to zero
// R06 - polarity 0 active low, 1 high
// R07 - jolt wakes only when its enable set
// R08 - enabled event in sleep raises wake request
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module swg_top (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       srst,
  // avalon-mm slave
  input  wire logic [swg_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [3:0]                 avs_byteenable,
  input  wire logic [31:0]                avs_writedata,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  // detection engines and power-mode controller
  input  wire logic [swg_pkg::NUM_SRC-1:0] det_event,
  input  wire logic                        sleep_state,
  output logic                             wake_req,
  // internal interrupt lines and pins
  input  wire logic [swg_pkg::NUM_PIN-1:0] irq_line,
  output logic [swg_pkg::NUM_PIN-1:0]      int_pin,
  // software interrupt
  output logic                             irq
);
  import swg_pkg::*;

  function automatic logic [31:0] widen5(input logic [4:0] v);
    widen5 = {27'h0000000, v};
  endfunction

  swg_src_t            wake_en_reg,  wake_en_next;
  logic                pol_reg,      pol_next;
  swg_src_t            stat_reg,     stat_next;
  swg_src_t            mask_reg,     mask_next;
  logic                wait_reg,     wait_next;
  logic [31:0]         rdata_reg,    rdata_next;
  logic                wake_reg,     wake_next;
  logic [NUM_PIN-1:0]  pin_reg,      pin_next;
  logic                irq_reg,      irq_next;
  logic                req;
  logic                acc;
  logic                wr_lane0;

  swg_gate_if gif ();

  assign gif.wake_en = wake_en_reg;
  assign gif.events  = det_event;
  assign gif.sleep   = sleep_state;

  swg_wake_gate u_gate (
    .gif (gif.gate)
  );

  assign req      = avs_read | avs_write;
  // access completes in the one cycle waitrequest is low
  assign acc      = req & ~wait_reg;
  assign wr_lane0 = acc & avs_write & avs_byteenable[0];

  // bus handshake and read data
  always_comb begin
    wait_next  = ~(req & wait_reg);
    rdata_next = rdata_reg;
    if (req && wait_reg && avs_read) begin
      case (avs_address)
        OFS_WAKE_EN:  rdata_next = widen5(wake_en_reg);
        OFS_PIN_CFG:  rdata_next = {31'h00000000, pol_reg};
        OFS_EVT_STAT: rdata_next = widen5(stat_reg);
        OFS_EVT_MASK: rdata_next = widen5(mask_reg);
        OFS_STATE: begin
          rdata_next = 32'h00000000;
          rdata_next[POS_SLEEP]    = sleep_state;
          rdata_next[POS_WAKE_REQ] = wake_reg;
          rdata_next[POS_RAW_EVT +: NUM_SRC] = det_event;
        end
        default:      rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  // configuration registers
  always_comb begin
    wake_en_next = wake_en_reg;
    pol_next     = pol_reg;
    mask_next    = mask_reg;
    if (wr_lane0) begin
      case (avs_address)
        OFS_WAKE_EN:  wake_en_next = avs_writedata[NUM_SRC-1:0];
        OFS_PIN_CFG:  pol_next     = avs_writedata[POS_POLARITY]; // R05
        OFS_EVT_MASK: mask_next    = avs_writedata[NUM_SRC-1:0];
        default:      ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_en_reg <= RST_WAKE_EN;
      pol_reg     <= RST_POLARITY; // R05
      mask_reg    <= RST_EVT_MASK;
    end else begin
      wake_en_reg <= wake_en_next;
      pol_reg     <= pol_next;
      mask_reg    <= mask_next;
    end
  end

  // wake request, sticky status, interrupt and pins
  always_comb begin
    stat_next = stat_reg;
    if (wr_lane0 && avs_address == OFS_EVT_STAT) begin
      stat_next = stat_reg & ~avs_writedata[NUM_SRC-1:0];
    end
    // a hit in the clearing cycle must not be lost
    stat_next = stat_next | gif.hit;
    wake_next = |gif.hit; // R08
    irq_next  = |(stat_next & mask_reg);
    // pol 0 drives the pin low while the line is asserted
    pin_next  = pol_reg ? irq_line : ~irq_line; // R06
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_reg <= '0;
      wake_reg <= 1'b0;
      irq_reg  <= 1'b0;
      pin_reg  <= RST_PIN;
    end else begin
      stat_reg <= stat_next;
      wake_reg <= wake_next;
      irq_reg  <= irq_next;
      pin_reg  <= pin_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign wake_req        = wake_reg;
  assign int_pin         = pin_reg;
  assign irq             = irq_reg;

  property p_pulse_gate;
    @(posedge core_clk) disable iff (srst)
    sleep_state && det_event == 5'h01 |=> wake_reg == $past(wake_en_reg[SRC_PULSE]);
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("pulse gating wrong"); // R01

  property p_ch1_gate;
    @(posedge core_clk) disable iff (srst)
    sleep_state && det_event == 5'h02 |=> wake_reg == $past(wake_en_reg[SRC_FMCH1]);
  endproperty
  a_ch1_gate: assert property (p_ch1_gate) else $error("motion ch1 gating wrong"); // R02

  property p_ch2_gate;
    @(posedge core_clk) disable iff (srst)
    sleep_state && det_event == 5'h04 && !wake_en_reg[SRC_FMCH2] |=> !wake_reg;
  endproperty
  a_ch2_gate: assert property (p_ch2_gate) else $error("motion ch2 not bypassed"); // R03

  property p_orient_wake;
    @(posedge core_clk) disable iff (srst)
    sleep_state && det_event[SRC_ORIENT] && wake_en_reg[SRC_ORIENT]
      |=> wake_reg && stat_reg[SRC_ORIENT];
  endproperty
  a_orient_wake: assert property (p_orient_wake) else $error("orientation did not wake"); // R04

  property p_pol_reset;
    @(posedge core_clk)
    srst |=> !pol_reg && int_pin == RST_PIN;
  endproperty
  a_pol_reset: assert property (p_pol_reset) else $error("polarity not reset to 0"); // R05

  property p_pin_level;
    @(posedge core_clk) disable iff (srst)
    ##1 $stable(pol_reg) |-> int_pin == ($past(pol_reg) ? $past(irq_line) : ~$past(irq_line));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin polarity wrong"); // R06

  property p_jolt_gate;
    @(posedge core_clk) disable iff (srst)
    sleep_state && det_event == 5'h10 |=> wake_reg == $past(wake_en_reg[SRC_JOLT]);
  endproperty
  a_jolt_gate: assert property (p_jolt_gate) else $error("jolt gating wrong"); // R07

  property p_no_wake_awake;
    @(posedge core_clk) disable iff (srst)
    !sleep_state || (det_event & wake_en_reg) == 5'h00 |=> !wake_reg;
  endproperty
  a_no_wake_awake: assert property (p_no_wake_awake) else $error("spurious wake request"); // R08

  property p_wake_any;
    @(posedge core_clk) disable iff (srst)
    sleep_state && (det_event & wake_en_reg) != 5'h00 |=> wake_reg;
  endproperty
  a_wake_any: assert property (p_wake_any) else $error("enabled event did not wake"); // R08

  // one wait-free cycle per request, so a held request is never taken on two cycles in a row
  property p_wait_pulse;
    @(posedge core_clk) disable iff (srst)
    !wait_reg |=> wait_reg;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

  property p_set_wins;
    @(posedge core_clk) disable iff (srst)
    gif.hit[SRC_PULSE] |=> stat_reg[SRC_PULSE] ##1 stat_reg[SRC_PULSE] ||
      $past(wr_lane0 && avs_address == OFS_EVT_STAT && avs_writedata[SRC_PULSE]);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("status event lost"); // R08
endmodule

// *** verification/swg_host_model.sv ***
// host side model that decodes the interrupt pins
`timescale 1ns/1ps
module swg_host_model (
  // pins and host belief of polarity
  input  wire logic [1:0] int_pin,
  input  wire logic       pol_high,
  // decoded request per pin
  output logic [1:0]      pin_active
);
  // host must know the programmed polarity to read a pin
  assign pin_active = pol_high ? int_pin : ~int_pin;
endmodule

// *** verification/tb.sv ***
// self-checking bench for the sleep wake source gating block
`timescale 1ns/1ps
module tb;
  import swg_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_be = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [4:0]  det_event = 5'h00;
  logic        sleep_state = 1'b0;
  logic        wake_req;
  logic [1:0]  irq_line = 2'h0;
  logic [1:0]  int_pin;
  logic        irq;
  logic        pol = 1'b0;
  logic [1:0]  act;
  logic [31:0] rv;
  int          errors = 0;
  int          cmp_count = 0;
  always #5 core_clk = ~core_clk;
  swg_top i_swg_top (.core_clk(core_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_be),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .det_event(det_event), .sleep_state(sleep_state),
    .wake_req(wake_req), .irq_line(irq_line), .int_pin(int_pin), .irq(irq));
  swg_host_model i_swg_host_model (.int_pin(int_pin), .pol_high(pol), .pin_active(act));
  task automatic final_report();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  initial begin
    #100us;
    errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd_chk(OFS_PIN_CFG, 32'h0);
    rd_chk(OFS_WAKE_EN, 32'h0);
    step(1);
    chk({30'h0, int_pin}, 32'h3);
    @(posedge core_clk) irq_line <= 2'h1;
    step(2);
    chk({30'h0, act}, 32'h1);
    @(posedge core_clk) sleep_state <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk) det_event <= 5'h01 << i;
      step(3);
      chk({31'h0, wake_req}, 32'h0);
      bus(1'b1, OFS_WAKE_EN, 32'h01 << i);
      step(2);
      chk({31'h0, wake_req}, 32'h1);
      rd_chk(OFS_EVT_STAT, 32'h01 << i);
      @(posedge core_clk) det_event <= 5'h00;
      bus(1'b1, OFS_EVT_STAT, 32'h01 << i);
      rd_chk(OFS_EVT_STAT, 32'h0);
      bus(1'b1, OFS_WAKE_EN, 32'h0);
    end
    bus(1'b1, OFS_WAKE_EN, 32'h1f);
    rd_chk(OFS_STATE, 32'h1);
    @(posedge core_clk) sleep_state <= 1'b0;
    @(posedge core_clk) det_event <= 5'h1f;
    step(3);
    chk({31'h0, wake_req}, 32'h0);
    rd_chk(OFS_EVT_STAT, 32'h0);
    // event held while asleep, only bit 2 unmasked
    bus(1'b1, OFS_EVT_MASK, 32'h04);
    @(posedge core_clk) sleep_state <= 1'b1;
    step(3);
    chk({31'h0, irq}, 32'h1);
    // clear while the event still stands: the set must win
    bus(1'b1, OFS_EVT_STAT, 32'h04);
    rd_chk(OFS_EVT_STAT, 32'h1f);
    @(posedge core_clk) det_event <= 5'h00;
    bus(1'b1, OFS_EVT_STAT, 32'h04);
    step(3);
    chk({31'h0, irq}, 32'h0);
    rd_chk(OFS_EVT_STAT, 32'h1b);
    bus(1'b1, OFS_PIN_CFG, 32'h1);
    @(posedge core_clk) pol <= 1'b1;
    irq_line <= 2'h2;
    step(3);
    chk({30'h0, int_pin}, 32'h2);
    chk({30'h0, act}, 32'h2);
    // a write without lane 0 must leave the polarity alone
    @(posedge core_clk) avs_be <= 4'he;
    bus(1'b1, OFS_PIN_CFG, 32'h0);
    avs_be <= 4'hf;
    rd_chk(OFS_PIN_CFG, 32'h1);
    rd_chk(5'h14, 32'h0);
    final_report();
  end
endmodule
